//--- motor_restart_defs.vh
// Constants for the motor restart inhibition block
`ifndef MOTOR_RESTART_DEFS_VH
`define MOTOR_RESTART_DEFS_VH

// Register word offsets (byte addresses, one 32-bit word each)
`define REG_MAX_STARTS      8'h00
`define REG_MIN_INTERVAL    8'h04
`define REG_NOM_CURRENT     8'h08
`define REG_START_THRESHOLD 8'h0c
`define REG_STATUS          8'h10
`define REG_IVL_REMAIN      8'h14
`define REG_LOCK_REMAIN     8'h18
`define REG_ALARM_REMAIN    8'h1c

// Status register field positions
`define ST_INHIBIT          0
`define ST_ALARM            1
`define ST_RUNNING          2
`define ST_LOCK             3
`define ST_IVL              4
`define ST_COUNT_LSB        8

// Setting limits and reset values
`define MAX_STARTS_MIN      5'h01
`define MAX_STARTS_MAX      5'h14
`define MAX_STARTS_RST      5'h03
`define MIN_IVL_MAX         10'h3e8
`define MIN_IVL_RST         10'h000
`define NOM_CURRENT_RST     16'h0400
`define START_THR_RST       16'h0800

// Timing: one tick is a tenth of a minute
`define TENTH_MIN_MS        6000
`define CLK_KHZ             100000
`define TENTH_MIN_CYCLES    (`TENTH_MIN_MS * `CLK_KHZ)
`define HOUR_TENTHS         10'h258
`define DEF_ELAPSED_MIN     120

`endif

//--- motor_restart_inhibit.v
// Motor restart inhibition: start detection, start counting, alarm and inhibit
// Functional notes
// - Start when current rises from below ten percent
// - Stopped when current falls below ten percent
// - Alarm at second-last start until limit or hour
// - Inhibit for minimum interval after each start
// - Inhibit one hour once hourly limit reached
// - Power-up elapsed default: 120 frees, 0 loads MIN_IVL_RST (zero), so also frees
// - Interval in tenth-minute steps; zero disables it
// - Exactly one parameter set, no groups
`include "motor_restart_defs.vh"

module motor_restart_inhibit #(
    parameter        CUR_W         = 16,
    parameter        MAX_SLOTS     = 20,
    parameter [31:0] TICK_CYCLES   = `TENTH_MIN_CYCLES,
    parameter        DEF_ELAPSED   = `DEF_ELAPSED_MIN
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire [15:0] current_i,
    input  wire [7:0]  addr_i,
    input  wire [31:0] wdata_i,
    input  wire        we_i,
    input  wire        re_i,
    output reg  [31:0] rdata_o,
    output wire        start_inhibit_o,
    output reg         restart_alarm_o,
    output reg         motor_running_o,
    output reg         motor_start_o
);

    // Clamp the starts-per-hour setting into one to twenty
    function [4:0] clamp_starts;
        input [31:0] v;
        begin
            if (v[31:0] < {27'h0, `MAX_STARTS_MIN}) begin
                clamp_starts = `MAX_STARTS_MIN;
            end else if (v[31:0] > {27'h0, `MAX_STARTS_MAX}) begin
                clamp_starts = `MAX_STARTS_MAX;
            end else begin
                clamp_starts = v[4:0];
            end
        end
    endfunction

    // Clamp the minimum interval setting to its top value
    function [9:0] clamp_ivl;
        input [31:0] v;
        begin
            if (v[31:0] > {22'h0, `MIN_IVL_MAX}) begin
                clamp_ivl = `MIN_IVL_MAX;
            end else begin
                clamp_ivl = v[9:0];
            end
        end
    endfunction

    // Settings: a single set, no alternate groups
    reg  [4:0]       max_starts;
    reg  [9:0]       min_interval;
    reg  [15:0]      nom_current;
    reg  [15:0]      start_detect_threshold;

    // Motor state and timers
    reg              seen_low;
    reg  [9:0]       ivl_timer;
    reg  [9:0]       lock_timer;
    reg  [9:0]       alarm_timer;
    reg  [31:0]      div_cnt;
    reg  [9:0]       slot_age [0:MAX_SLOTS-1];
    reg  [MAX_SLOTS-1:0] slot_used;

    // Combinational helpers
    reg  [4:0]       start_cnt;
    reg  [4:0]       free_idx;
    reg              free_found;
    wire             tick;
    wire             below_tenth;
    wire             above_start;
    wire             start_ev;
    wire [4:0]       cnt_after;
    wire [19:0]      cur_x10;
    integer          i;
    integer          j;
    integer          k;

    assign tick = (div_cnt == TICK_CYCLES - 32'h1);

    // Ten times the current against nominal gives the ten percent test
    assign cur_x10     = {1'b0, current_i, 3'b000} + {3'b000, current_i, 1'b0};
    assign below_tenth = (cur_x10 < {4'h0, nom_current});
    assign above_start = (current_i > start_detect_threshold);

    // A start needs a prior low period, then current above threshold
    assign start_ev  = seen_low & above_start;
    assign cnt_after = start_cnt + 5'h01;

    // Inhibit while either the interval or the hourly lock runs
    assign start_inhibit_o = (ivl_timer != 10'h000) | (lock_timer != 10'h000);

    // Number of starts still remembered within the last hour
    always @* begin
        start_cnt = 5'h00;
        for (j = 0; j < MAX_SLOTS; j = j + 1) begin
            start_cnt = start_cnt + {4'h0, slot_used[j]};
        end
    end

    // Lowest free slot for recording a new start
    always @* begin
        free_found = 1'b0;
        free_idx   = 5'h00;
        for (k = MAX_SLOTS - 1; k >= 0; k = k - 1) begin
            if (!slot_used[k]) begin
                free_found = 1'b1;
                free_idx   = k[4:0];
            end
        end
    end

    // Tenth-minute timebase divider
    always @(posedge clk_i) begin
        if (rst_i || tick) begin
            div_cnt <= 32'h0;
        end else begin
            div_cnt <= div_cnt + 32'h1;
        end
    end

    // Settings written by software; start limit and interval clamped to their ranges
    always @(posedge clk_i) begin
        if (rst_i) begin
            max_starts             <= `MAX_STARTS_RST;
            min_interval           <= `MIN_IVL_RST;
            nom_current            <= `NOM_CURRENT_RST;
            start_detect_threshold <= `START_THR_RST;
        end else if (we_i) begin
            if (addr_i == `REG_MAX_STARTS) begin
                max_starts <= clamp_starts(wdata_i);
            end else if (addr_i == `REG_MIN_INTERVAL) begin
                min_interval <= clamp_ivl(wdata_i);
            end else if (addr_i == `REG_NOM_CURRENT) begin
                nom_current <= wdata_i[15:0];
            end else if (addr_i == `REG_START_THRESHOLD) begin
                start_detect_threshold <= wdata_i[15:0];
            end
        end
    end

    // Running/stopped tracking from the measured current
    always @(posedge clk_i) begin
        if (rst_i) begin
            seen_low        <= 1'b0;
            motor_running_o <= 1'b0;
            motor_start_o   <= 1'b0;
        end else begin
            motor_start_o <= start_ev;
            if (start_ev) begin
                seen_low        <= 1'b0;
                motor_running_o <= 1'b1;
            end else if (below_tenth) begin
                seen_low        <= 1'b1;
                motor_running_o <= 1'b0;
            end
        end
    end

    // Start history: each slot ages and is dropped after one hour
    always @(posedge clk_i) begin
        if (rst_i) begin
            slot_used <= {MAX_SLOTS{1'b0}};
            for (i = 0; i < MAX_SLOTS; i = i + 1) begin
                slot_age[i] <= 10'h000;
            end
        end else begin
            for (i = 0; i < MAX_SLOTS; i = i + 1) begin
                if (start_ev && free_found && free_idx == i[4:0]) begin
                    slot_used[i] <= 1'b1;
                    slot_age[i]  <= 10'h000;
                end else if (tick && slot_used[i]) begin
                    if (slot_age[i] == `HOUR_TENTHS - 10'h001) begin
                        slot_used[i] <= 1'b0;
                    end else begin
                        slot_age[i] <= slot_age[i] + 10'h001;
                    end
                end
            end
        end
    end

    // Minimum interval timer; power-up load follows the elapsed default
    always @(posedge clk_i) begin
        if (rst_i) begin
            if (DEF_ELAPSED == 0) begin
                ivl_timer <= `MIN_IVL_RST;
            end else begin
                ivl_timer <= 10'h000;
            end
        end else if (start_ev) begin
            ivl_timer <= min_interval;
        end else if (tick && ivl_timer != 10'h000) begin
            ivl_timer <= ivl_timer - 10'h001;
        end
    end

    // Hourly lock once the start count reaches the limit
    always @(posedge clk_i) begin
        if (rst_i) begin
            lock_timer <= 10'h000;
        end else if (start_ev && cnt_after >= max_starts) begin
            lock_timer <= `HOUR_TENTHS;
        end else if (tick && lock_timer != 10'h000) begin
            lock_timer <= lock_timer - 10'h001;
        end
    end

    // Alarm from the second-last start until limit or one hour
    always @(posedge clk_i) begin
        if (rst_i) begin
            restart_alarm_o <= 1'b0;
            alarm_timer     <= 10'h000;
        end else if (start_ev && max_starts > 5'h01 &&
                     cnt_after == max_starts - 5'h01) begin
            restart_alarm_o <= 1'b1;
            alarm_timer     <= `HOUR_TENTHS;
        end else if (restart_alarm_o) begin
            if (start_cnt >= max_starts ||
                (start_ev && cnt_after >= max_starts)) begin
                restart_alarm_o <= 1'b0;
                alarm_timer     <= 10'h000;
            end else if (tick) begin
                if (alarm_timer == 10'h001) begin
                    restart_alarm_o <= 1'b0;
                end
                alarm_timer <= alarm_timer - 10'h001;
            end
        end
    end

    // Read port: data stand in the cycle after the read strobe
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o <= 32'h0;
        end else if (re_i) begin
            if (addr_i == `REG_MAX_STARTS) begin
                rdata_o <= {27'h0, max_starts};
            end else if (addr_i == `REG_MIN_INTERVAL) begin
                rdata_o <= {22'h0, min_interval};
            end else if (addr_i == `REG_NOM_CURRENT) begin
                rdata_o <= {16'h0, nom_current};
            end else if (addr_i == `REG_START_THRESHOLD) begin
                rdata_o <= {16'h0, start_detect_threshold};
            end else if (addr_i == `REG_STATUS) begin
                rdata_o <= 32'h0;
                rdata_o[`ST_INHIBIT] <= start_inhibit_o;
                rdata_o[`ST_ALARM]   <= restart_alarm_o;
                rdata_o[`ST_RUNNING] <= motor_running_o;
                rdata_o[`ST_LOCK]    <= (lock_timer != 10'h000);
                rdata_o[`ST_IVL]     <= (ivl_timer != 10'h000);
                rdata_o[`ST_COUNT_LSB+4:`ST_COUNT_LSB] <= start_cnt;
            end else if (addr_i == `REG_IVL_REMAIN) begin
                rdata_o <= {22'h0, ivl_timer};
            end else if (addr_i == `REG_LOCK_REMAIN) begin
                rdata_o <= {22'h0, lock_timer};
            end else if (addr_i == `REG_ALARM_REMAIN) begin
                rdata_o <= {22'h0, alarm_timer};
            end else begin
                rdata_o <= 32'h0;
            end
        end else begin
            rdata_o <= 32'h0;
        end
    end

endmodule

//--- motor_model.sv
// Motor and breaker model: the breaker closes on request unless inhibited
module motor_model (
    input  wire logic        clk_i,
    input  wire logic        close_i,
    input  wire logic        open_i,
    input  wire logic        inhibit_i,
    input  wire logic [15:0] run_lvl_i,
    input  wire logic [15:0] idle_lvl_i,
    output logic      [15:0] current_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic closed = 1'b0;
    // Close coil is cut while the inhibit contact is active
    always @(posedge clk_i) begin
        if (open_i) begin
            closed <= 1'b0;
        end else if (close_i && !inhibit_i) begin
            closed <= 1'b1;
        end
    end
    assign current_o = closed ? run_lvl_i : idle_lvl_i;
endmodule

//--- motor_restart_inhibit_asserts.sv
// Concurrent checks on the motor restart inhibition ports
`include "motor_restart_defs.vh"
module motor_restart_inhibit_asserts (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [15:0] current_i,
    input wire logic [7:0]  addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic        we_i,
    input wire logic        re_i,
    input wire logic [31:0] rdata_o,
    input wire logic        start_inhibit_o,
    input wire logic        restart_alarm_o,
    input wire logic        motor_running_o,
    input wire logic        motor_start_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] nom;
    logic [15:0] thr;
    wire         below = ({4'h0, current_i} * 20'h0000a) < {4'h0, nom};
    wire         above = current_i > thr;
    // Shadow the current settings written over the register bus
    always @(posedge clk_i) begin
        if (rst_i) begin
            nom <= `NOM_CURRENT_RST;
            thr <= `START_THR_RST;
        end else if (we_i && addr_i == `REG_NOM_CURRENT) begin
            nom <= wdata_i[15:0];
        end else if (we_i && addr_i == `REG_START_THRESHOLD) begin
            thr <= wdata_i[15:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_pulse;
        motor_start_o ##1 !motor_start_o;
    endsequence
    AST_START_PULSE: assert property ($rose(motor_running_o) |-> ##[0:1] s_pulse)
        else $error("start pulse missing or too long");
    AST_START_CAUSE: assert property ($rose(motor_running_o) |-> $past(above))
        else $error("running without current above threshold");
    AST_STOP: assert property (motor_running_o && below |=> !motor_running_o)
        else $error("motor not stopped on low current");
    AST_INHIBIT_RISE: assert property ($rose(start_inhibit_o) |-> $rose(motor_running_o))
        else $error("inhibit rose without a start");
    AST_ALARM_RISE: assert property ($rose(restart_alarm_o) |-> $rose(motor_running_o))
        else $error("alarm rose without a start");
    AST_LOCK_AT_MAX: assert property ($fell(restart_alarm_o) && $rose(motor_running_o)
        |-> start_inhibit_o)
        else $error("no inhibit at start limit");
    AST_RDATA_IDLE: assert property (!$past(re_i) |-> rdata_o == 32'h00000000)
        else $error("read data outside read answer");
    AST_STATUS: assert property ($past(re_i) && $past(addr_i) == `REG_STATUS |->
        rdata_o[2:0] ==
        {$past(motor_running_o), $past(restart_alarm_o), $past(start_inhibit_o)})
        else $error("status bits differ from outputs");
endmodule
bind motor_restart_inhibit motor_restart_inhibit_asserts u_asserts (.clk_i, .rst_i,
    .current_i, .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .start_inhibit_o,
    .restart_alarm_o, .motor_running_o, .motor_start_o);

//--- motor_restart_inhibit_test.sv
// Testbench for the motor restart inhibition block
`include "motor_restart_defs.vh"
module motor_restart_inhibit_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h00000000;
    logic        we_i = 1'b0;
    logic        re_i = 1'b0;
    logic        close_req = 1'b0;
    logic        open_req = 1'b0;
    logic [15:0] run_lvl = 16'h0900;
    logic [15:0] idle_lvl = 16'h0000;
    logic [15:0] current_i;
    logic [31:0] rdata_o;
    logic        start_inhibit_o, restart_alarm_o, motor_running_o, motor_start_o;
    logic        rd_seen = 1'b0;
    logic [31:0] exp_q[$];
    int          bad_count = 0;
    int          checked = 0;
    int          n;
    always #5 clk_i = ~clk_i;
    motor_restart_inhibit #(.TICK_CYCLES(32'd4)) u_dut (.clk_i, .rst_i, .current_i, .addr_i,
        .wdata_i, .we_i, .re_i, .rdata_o, .start_inhibit_o, .restart_alarm_o,
        .motor_running_o, .motor_start_o);
    motor_model u_motor (.clk_i, .close_i(close_req), .open_i(open_req),
        .inhibit_i(start_inhibit_o), .run_lvl_i(run_lvl), .idle_lvl_i(idle_lvl),
        .current_o(current_i));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One bus cycle; a read notes its expected answer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        we_i <= w;
        re_i <= !w;
        if (!w) exp_q.push_back(d);
        @(posedge clk_i);
        we_i <= 1'b0;
        re_i <= 1'b0;
    endtask
    // Compare each read answer with the oldest note
    always @(posedge clk_i) begin
        if (rd_seen) chk("rdata_o", exp_q.pop_front(), rdata_o);
        rd_seen <= re_i;
    end
    task automatic run_start(input logic ok);
        @(posedge clk_i);
        close_req <= 1'b1;
        @(posedge clk_i);
        close_req <= 1'b0;
        for (n = 0; n < 20 && motor_start_o !== 1'b1; n++) @(posedge clk_i);
        chk("motor_start_o", ok, motor_start_o);
        @(posedge clk_i);
    endtask
    task automatic stop_motor();
        @(posedge clk_i);
        open_req <= 1'b1;
        @(posedge clk_i);
        open_req <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("motor_running_o", 1'b0, motor_running_o);
    endtask
    task automatic wait_free();
        for (n = 0; n < 3000 && start_inhibit_o !== 1'b0; n++) @(posedge clk_i);
    endtask
    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Watchdog against a hung wait
    initial begin
        #60000;
        bad_count++;
        finish_test();
    end
    initial begin
        void'($urandom(32'h4f45));
        idle_lvl <= 16'($urandom % 100);
        run_lvl <= 16'h0900 + 16'($urandom % 256);
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("start_inhibit_o", 1'b0, start_inhibit_o);
        bus(1'b0, `REG_MAX_STARTS, 32'h3);
        bus(1'b0, `REG_MIN_INTERVAL, 32'h0);
        bus(1'b0, `REG_NOM_CURRENT, 32'h400);
        bus(1'b0, `REG_START_THRESHOLD, 32'h800);
        bus(1'b0, 8'h20, 32'h0);
        bus(1'b1, `REG_STATUS, 32'hffff);
        bus(1'b0, `REG_STATUS, 32'h0);
        bus(1'b1, `REG_MAX_STARTS, 32'h0);
        bus(1'b0, `REG_MAX_STARTS, 32'h1);
        bus(1'b1, `REG_MAX_STARTS, 32'h1f);
        bus(1'b0, `REG_MAX_STARTS, 32'h14);
        bus(1'b1, `REG_MAX_STARTS, 32'h3);
        bus(1'b1, `REG_MIN_INTERVAL, 32'h7ff);
        bus(1'b0, `REG_MIN_INTERVAL, {22'h0, `MIN_IVL_MAX});
        bus(1'b1, `REG_MIN_INTERVAL, 32'h2);
        $display("test registers done");
        run_start(1'b1);
        chk("start_inhibit_o", 1'b1, start_inhibit_o);
        wait_free();
        chk("interval_span", 1'b1, n > 0 && n < 12);
        stop_motor();
        $display("test interval done");
        bus(1'b1, `REG_MIN_INTERVAL, 32'h0);
        run_start(1'b1);
        chk("restart_alarm_o", 1'b1, restart_alarm_o);
        chk("start_inhibit_o", 1'b0, start_inhibit_o);
        stop_motor();
        run_start(1'b1);
        chk("restart_alarm_o", 1'b0, restart_alarm_o);
        chk("start_inhibit_o", 1'b1, start_inhibit_o);
        stop_motor();
        bus(1'b0, `REG_STATUS, 32'h0309);
        run_start(1'b0);
        wait_free();
        chk("lock_span", 1'b1, n > 2300 && n < 2410);
        run_start(1'b1);
        repeat (4) @(posedge clk_i);
        $display("test start limit done");
        finish_test();
    end
endmodule
